// ===== core/timer16_map.vh
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// Byte offsets on the Wishbone bus, one register per aligned 32-bit word
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_CTRL_C 8'h08
`define OFS_CNT_LO 8'h0c
`define OFS_CNT_HI 8'h10
`define OFS_CMPA_LO 8'h14
`define OFS_CMPA_HI 8'h18
`define OFS_CMPB_LO 8'h1c
`define OFS_CMPB_HI 8'h20
`define OFS_CAP_LO 8'h24
`define OFS_CAP_HI 8'h28
`define OFS_IRQ_FLAGS 8'h2c
`define OFS_IRQ_MASK 8'h30
`define OFS_POWER 8'h34
// Control A fields: waveform mode in [2:0], compare A output mode [5:4],
// compare B output mode [7:6]
`define CA_MODE_LSB 0
`define CA_MODE_MSB 2
`define CA_COMA_LSB 4
`define CA_COMB_LSB 6
// Control B fields: clock select [2:0], capture edge [6], filter [7]
`define CB_CS_LSB 0
`define CB_CS_MSB 2
`define CB_CAP_EDGE 6
`define CB_FILTER 7
// Control C fields: capture source select [0]
`define CC_CAP_SRC 0
// Flag and mask bit positions
`define IRQ_OVF 0
`define IRQ_CMPA 1
`define IRQ_CMPB 2
`define IRQ_CAP 3
// Power gate bit position in the power register
`define PWR_GATE 0
// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_POWER 8'h01
// Fixed counter values
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hffff
`define CNT_FIX8 16'h00ff
`define CNT_FIX9 16'h01ff
`define CNT_FIX10 16'h03ff
// Capture filter length in system clocks
`define FILTER_LEN 4
// Waveform modes
`define MODE_NORMAL 3'h0
`define MODE_PWM8 3'h1
`define MODE_PWM9 3'h2
`define MODE_PWM10 3'h3
`define MODE_CTC_A 3'h4
`define MODE_CTC_CAP 3'h5
`define MODE_PWM_A 3'h6
`define MODE_PWM_CAP 3'h7
`endif

// ===== core/wide_timer_counter_core.v
`timescale 1ns/100ps
`default_nettype none
`include "timer16_map.vh"

// Summary of operation
// - Counter at zero is flagged as bottom for waveform and flag logic.
// - Counter at all ones is flagged as max.
// - Top is max or compare A value depending on the mode.
// - Top may instead come from capture value or fixed values.
// - With compare A as top in PWM, output A gives no PWM.
// - Compare A as top is double buffered in PWM mode, updated at top; CTC mode loads it at once.
// - With capture value as top, compare A keeps its own PWM output.
// - Tick taken from prescaler or external pin, source and edge chosen.
// - With no clock source selected the counter holds still.
// - Both buffered compare values are compared with counter every cycle.
// - A compare match sets that unit's match flag.
// - Compare results drive PWM or toggled frequency on output pins.
// - Selected edge of capture pin or comparator copies counter to capture.
// - Optional digital filter rejects short spikes on capture trigger.
// - One shared high-byte latch serves all 16-bit registers.
// - Control registers are read and written directly, no latch.
// - Every timer interrupt request is visible in the flag register.
// - Each interrupt request is gated by its own mask bit.
// - Four sources: overflow, compare A, compare B, capture.
// - Clear-on-compare mode reloads counter to zero after the match.
// - Timer stays disabled while the power gate bit is one.
// - High byte written first to latch; low write loads both bytes.
// - Compare registers are read directly without the shared latch.
// - CPU counter write beats any clear or count in that cycle.
// - Counter counts up or down by one per tick as mode directs.
module wide_timer_counter_core #(
  parameter FILTER_LEN = `FILTER_LEN
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_tick_pin_i,
  input wire capture_trigger_pin_i,
  input wire comparator_i,
  output reg [1:0] compare_output_pins_o,
  output reg irq_ovf_o,
  output reg irq_cmpa_o,
  output reg irq_cmpb_o,
  output reg irq_cap_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] ctrl_a;
  reg [7:0] ctrl_b;
  reg [7:0] ctrl_c;
  reg [15:0] counter_value;
  reg [15:0] compare_a_value;
  reg [15:0] compare_b_value;
  reg [15:0] cmpa_buf;
  reg [15:0] cmpb_buf;
  reg [15:0] capture_value;
  reg [7:0] high_latch;
  reg [3:0] timer_irq_flags;
  reg [3:0] timer_irq_mask;
  reg timer_power_gate_bit;
  reg count_down;
  reg [9:0] prescale;
  reg [1:0] ext_sync;
  reg ext_prev;
  reg [1:0] cap_sync;
  reg [1:0] cmp_sync;
  reg [FILTER_LEN-1:0] cap_hist;
  reg cap_level;
  reg cap_prev;

  wire [2:0] mode = ctrl_a[`CA_MODE_MSB:`CA_MODE_LSB];
  wire [1:0] com_a = ctrl_a[`CA_COMA_LSB+1:`CA_COMA_LSB];
  wire [1:0] com_b = ctrl_a[`CA_COMB_LSB+1:`CA_COMB_LSB];
  wire [2:0] clk_sel = ctrl_b[`CB_CS_MSB:`CB_CS_LSB];
  wire running = ~timer_power_gate_bit;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lo = bus_req & wb_we_i & wb_sel_i[0];
  // A gated timer still acks writes but drops them, power register aside
  wire wr_ev = wr_lo & running;
  wire rd_ev = bus_req & ~wb_we_i;
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire wr_cnt_lo = wr_ev & (wb_adr_i == `OFS_CNT_LO);
  wire wr_cmpa_lo = wr_ev & (wb_adr_i == `OFS_CMPA_LO);
  wire wr_cmpb_lo = wr_ev & (wb_adr_i == `OFS_CMPB_LO);
  wire wr_cap_lo = wr_ev & (wb_adr_i == `OFS_CAP_LO);
  wire wr_any_hi = wr_ev & ((wb_adr_i == `OFS_CNT_HI) |
    (wb_adr_i == `OFS_CMPA_HI) | (wb_adr_i == `OFS_CMPB_HI) |
    (wb_adr_i == `OFS_CAP_HI));

  ////////////////////////////////////////////////////////////////////////
  // Tick generation: prescaler taps or synchronised pin edge
  wire ext_rise = ext_sync[1] & ~ext_prev;
  wire ext_fall = ~ext_sync[1] & ext_prev;
  reg tick;
  always @* begin
    case (clk_sel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (prescale[2:0] == 3'h7);
      3'h3: tick = (prescale[5:0] == 6'h3f);
      3'h4: tick = (prescale[7:0] == 8'hff);
      3'h5: tick = (prescale[9:0] == 10'h3ff);
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end
  wire timer_tick = tick & running;

  // Synchronise all three pins before any edge logic sees them
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale <= 10'h000;
      ext_sync <= 2'h0;
      ext_prev <= 1'b0;
      cap_sync <= 2'h0;
      cmp_sync <= 2'h0;
    end else begin
      prescale <= running ? prescale + 10'h001 : 10'h000;
      ext_sync <= {ext_sync[0], ext_tick_pin_i};
      ext_prev <= ext_sync[1];
      cap_sync <= {cap_sync[0], capture_trigger_pin_i};
      cmp_sync <= {cmp_sync[0], comparator_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Top selection
  reg [15:0] top;
  always @* begin
    case (mode)
      `MODE_PWM8: top = `CNT_FIX8;
      `MODE_PWM9: top = `CNT_FIX9;
      `MODE_PWM10: top = `CNT_FIX10;
      `MODE_CTC_A: top = compare_a_value;
      `MODE_PWM_A: top = compare_a_value;
      `MODE_CTC_CAP: top = capture_value;
      `MODE_PWM_CAP: top = capture_value;
      default: top = `CNT_MAX;
    endcase
  end
  wire pwm_mode = (mode == `MODE_PWM8) | (mode == `MODE_PWM9) |
    (mode == `MODE_PWM10) | (mode == `MODE_PWM_A) | (mode == `MODE_PWM_CAP);
  wire ctc_mode = (mode == `MODE_CTC_A) | (mode == `MODE_CTC_CAP);
  wire at_bottom = (counter_value == `CNT_BOTTOM);
  wire at_max = (counter_value == `CNT_MAX);
  wire at_top = (counter_value == top);
  wire match_a = (counter_value == compare_a_value);
  wire match_b = (counter_value == compare_b_value);
  // Phase correct PWM turns at top and at bottom
  wire turn_down = pwm_mode & ~count_down & at_top;
  wire turn_up = pwm_mode & count_down & at_bottom;
  // Outside PWM the counter only counts up, so no stale down state lingers
  wire dir_next = ~pwm_mode ? 1'b0 :
    (turn_down ? 1'b1 : (turn_up ? 1'b0 : count_down));
  wire overflow = timer_tick & (pwm_mode ? turn_up :
    (ctc_mode ? at_max : at_max | (mode == `MODE_NORMAL) & at_top));

  ////////////////////////////////////////////////////////////////////////
  // Counter unit
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      counter_value <= `RST_WORD;
      count_down <= 1'b0;
    end else if (wr_cnt_lo) begin
      counter_value <= {high_latch, wbyte};
    end else if (timer_tick) begin
      count_down <= dir_next;
      if (ctc_mode & at_top)
        counter_value <= `CNT_BOTTOM;
      else if (dir_next)
        counter_value <= counter_value - 16'h0001;
      else
        counter_value <= counter_value + 16'h0001;
    end
  end

  // Compare values load from buffer at top in PWM modes, else at once
  wire cmp_update = ~pwm_mode | (timer_tick & turn_down);
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmpa_buf <= `RST_WORD;
      cmpb_buf <= `RST_WORD;
      compare_a_value <= `RST_WORD;
      compare_b_value <= `RST_WORD;
    end else begin
      if (wr_cmpa_lo)
        cmpa_buf <= {high_latch, wbyte};
      if (wr_cmpb_lo)
        cmpb_buf <= {high_latch, wbyte};
      if (cmp_update) begin
        compare_a_value <= cmpa_buf;
        compare_b_value <= cmpb_buf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture unit with spike filter
  wire cap_src = ctrl_c[`CC_CAP_SRC] ? cmp_sync[1] : cap_sync[1];
  wire hist_all1 = &{cap_hist, cap_src};
  wire hist_all0 = ~|{cap_hist, cap_src};
  wire cap_filtered = ctrl_b[`CB_FILTER] ?
    (hist_all1 ? 1'b1 : (hist_all0 ? 1'b0 : cap_level)) : cap_src;
  wire cap_edge = ctrl_b[`CB_CAP_EDGE] ? (cap_level & ~cap_prev) :
    (~cap_level & cap_prev);
  // No capture while the capture register serves as the top
  wire cap_event = running & cap_edge & ~(mode == `MODE_CTC_CAP) &
    ~(mode == `MODE_PWM_CAP);
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_hist <= {FILTER_LEN{1'b0}};
      cap_level <= 1'b0;
      cap_prev <= 1'b0;
      capture_value <= `RST_WORD;
    end else begin
      cap_hist <= {cap_hist[FILTER_LEN-2:0], cap_src};
      cap_level <= cap_filtered;
      cap_prev <= cap_level;
      if (wr_cap_lo)
        capture_value <= {high_latch, wbyte};
      else if (cap_event)
        capture_value <= counter_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: set beats a write-one clear in the same cycle
  wire [3:0] ev;
  assign ev[`IRQ_OVF] = overflow;
  assign ev[`IRQ_CMPA] = timer_tick & match_a;
  assign ev[`IRQ_CMPB] = timer_tick & match_b;
  assign ev[`IRQ_CAP] = cap_event;
  wire [3:0] flag_clr = (wr_ev & (wb_adr_i == `OFS_IRQ_FLAGS)) ?
    wbyte[3:0] : 4'h0;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      timer_irq_flags <= 4'h0;
    else
      timer_irq_flags <= (timer_irq_flags & ~flag_clr) | ev;
  end

  // Interrupt lines, registered
  wire [3:0] irq_req = timer_irq_flags & timer_irq_mask;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_ovf_o <= 1'b0;
      irq_cmpa_o <= 1'b0;
      irq_cmpb_o <= 1'b0;
      irq_cap_o <= 1'b0;
    end else begin
      irq_ovf_o <= irq_req[`IRQ_OVF];
      irq_cmpa_o <= irq_req[`IRQ_CMPA];
      irq_cmpb_o <= irq_req[`IRQ_CMPB];
      irq_cap_o <= irq_req[`IRQ_CAP];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform outputs
  // Mode 1 toggles on match outside PWM; 2 clears on up match, 3 sets on up match
  function wave_next;
    input [1:0] com;
    input cur;
    input match;
    input at_bot;
    input pwm;
    input down;
    begin
      wave_next = cur;
      if (com == 2'h1 && !pwm && match)
        wave_next = ~cur;
      else if (com[1] && pwm && match)
        wave_next = down ? ~com[0] : com[0];
      else if (com[1] && !pwm && match)
        wave_next = com[0];
      else if (com[1] && pwm && at_bot && !match)
        wave_next = ~com[0];
    end
  endfunction
  // Compare A cannot make PWM when it is the top itself
  wire a_is_top_pwm = (mode == `MODE_PWM_A);
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      compare_output_pins_o <= 2'h0;
    else if (timer_tick) begin
      compare_output_pins_o[0] <= a_is_top_pwm ? 1'b0 :
        wave_next(com_a, compare_output_pins_o[0], match_a, at_bottom,
        pwm_mode, count_down);
      compare_output_pins_o[1] <= wave_next(com_b, compare_output_pins_o[1],
        match_b, at_bottom, pwm_mode, count_down);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direct registers and shared high byte latch
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_a <= `RST_BYTE;
      ctrl_b <= `RST_BYTE;
      ctrl_c <= `RST_BYTE;
      timer_irq_mask <= 4'h0;
      timer_power_gate_bit <= 1'b1;
      high_latch <= `RST_BYTE;
    end else begin
      if (wr_lo && wb_adr_i == `OFS_POWER)
        timer_power_gate_bit <= wbyte[`PWR_GATE];
      if (wr_ev && wb_adr_i == `OFS_CTRL_A)
        ctrl_a <= wbyte;
      if (wr_ev && wb_adr_i == `OFS_CTRL_B)
        ctrl_b <= wbyte;
      if (wr_ev && wb_adr_i == `OFS_CTRL_C)
        ctrl_c <= wbyte;
      if (wr_ev && wb_adr_i == `OFS_IRQ_MASK)
        timer_irq_mask <= wbyte[3:0];
      if (wr_any_hi)
        high_latch <= wbyte;
      else if (rd_ev && running && wb_adr_i == `OFS_CNT_LO)
        high_latch <= counter_value[15:8];
      else if (rd_ev && running && wb_adr_i == `OFS_CAP_LO)
        high_latch <= capture_value[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero and still ack
  reg [7:0] rbyte;
  always @* begin
    case (wb_adr_i)
      `OFS_CTRL_A: rbyte = ctrl_a;
      `OFS_CTRL_B: rbyte = ctrl_b;
      `OFS_CTRL_C: rbyte = ctrl_c;
      `OFS_CNT_LO: rbyte = counter_value[7:0];
      `OFS_CNT_HI: rbyte = high_latch;
      `OFS_CMPA_LO: rbyte = cmpa_buf[7:0];
      `OFS_CMPA_HI: rbyte = cmpa_buf[15:8];
      `OFS_CMPB_LO: rbyte = cmpb_buf[7:0];
      `OFS_CMPB_HI: rbyte = cmpb_buf[15:8];
      `OFS_CAP_LO: rbyte = capture_value[7:0];
      `OFS_CAP_HI: rbyte = high_latch;
      `OFS_IRQ_FLAGS: rbyte = {4'h0, timer_irq_flags};
      `OFS_IRQ_MASK: rbyte = {4'h0, timer_irq_mask};
      `OFS_POWER: rbyte = {7'h00, timer_power_gate_bit};
      default: rbyte = 8'h00;
    endcase
  end

  // One wait-free cycle: ack follows the request edge, drops next cycle
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ===== sim/wide_timer_counter_core_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_map.vh"
module wide_timer_counter_core_props (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_ovf_o,
  input wire logic irq_cmpa_o,
  input wire logic irq_cmpb_o,
  input wire logic irq_cap_o
);
  default clocking dclk @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [7:0] ca, cb, cc, msk;
  logic pwr;
  wire [3:0] irq = {irq_cap_o, irq_cmpb_o, irq_cmpa_o, irq_ovf_o};
  ////////////////////////////////////////
  // Shadow of accepted writes; a gated timer drops all but power
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ca <= 8'h00;
      cb <= 8'h00;
      cc <= 8'h00;
      msk <= 8'h00;
      pwr <= 1'b1;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `OFS_POWER)
        pwr <= wb_dat_i[0];
      else if (!pwr) begin
        case (wb_adr_i)
          `OFS_CTRL_A: ca <= wb_dat_i[7:0];
          `OFS_CTRL_B: cb <= wb_dat_i[7:0];
          `OFS_CTRL_C: cc <= wb_dat_i[7:0];
          `OFS_IRQ_MASK: msk <= wb_dat_i[7:0];
          default: ;
        endcase
      end
    end
  end
  ////////////////////////////////////////
  // Request taken, then a completed read of one address
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  // Only defined bits compared; spare bits may read as zero
  property p_rb(logic [7:0] a, logic [7:0] m, logic [7:0] v);
    s_rd(a) |-> (wb_dat_o[7:0] & m) == (v & m);
  endproperty
  AST_ACK_ONE: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_UNMAPPED: assert property (s_rd(8'h3c) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_CTRL_A: assert property (p_rb(`OFS_CTRL_A, 8'hf7, ca))
    else $error("control A read back wrong");
  AST_RD_CTRL_B: assert property (p_rb(`OFS_CTRL_B, 8'hc7, cb))
    else $error("control B read back wrong");
  AST_RD_CTRL_C: assert property (p_rb(`OFS_CTRL_C, 8'h01, cc))
    else $error("control C read back wrong");
  AST_RD_MASK: assert property (p_rb(`OFS_IRQ_MASK, 8'h0f, msk))
    else $error("mask read back wrong");
  AST_RD_POWER: assert property (p_rb(`OFS_POWER, 8'h01, {7'h0, pwr}))
    else $error("power bit read back wrong");
  AST_IRQ_GATED: assert property
    ((irq & ~(msk[3:0] | $past(msk[3:0]))) == 4'h0)
    else $error("interrupt line without its mask bit");
  AST_POWER_QUIET: assert property (pwr && $past(pwr) |-> irq == 4'h0)
    else $error("interrupt while power gated");
endmodule
bind wide_timer_counter_core wide_timer_counter_core_props u_props (
  .sys_clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_ovf_o, .irq_cmpa_o,
  .irq_cmpb_o, .irq_cap_o);
`default_nettype wire

// ===== sim/cpu_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  input wire logic sys_clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output var logic wb_cyc_o,
  output var logic wb_stb_o,
  output var logic wb_we_o,
  output var logic [7:0] wb_adr_o,
  output var logic [3:0] wb_sel_o,
  output var logic [31:0] wb_dat_o
);
  int gap = 0; // Idle cycles ahead of a request, to act slow
  // Idle bus from time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // One byte per classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk_i);
    repeat (gap) @(posedge sys_clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h000000, d};
    do @(posedge sys_clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o; // Released data must not look valid
  endtask
  // Wide write: high byte into the shared latch first
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, a + 8'h04, v[15:8], q);
    xfer(1'b1, a, v[7:0], q);
  endtask
  // Wide read: low byte first so the latch holds its high byte
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    xfer(1'b0, a, 8'h00, v[7:0]);
    xfer(1'b0, a + 8'h04, 8'h00, v[15:8]);
  endtask
endmodule
`default_nettype wire

// ===== sim/wide_timer_counter_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_map.vh"
module wide_timer_counter_core_tb;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ext_tick_pin_i = 1'b0;
  logic capture_trigger_pin_i = 1'b0;
  logic comparator_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, q;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0] compare_output_pins_o;
  logic irq_ovf_o, irq_cmpa_o, irq_cmpb_o, irq_cap_o;
  logic [15:0] v;
  int n_mismatch = 0;
  int n_checks = 0;
  typedef struct packed {logic [7:0] a, d, e;} row_t;
  // Address, byte written, byte read back
  row_t rows [6] = '{24'h00c6c6, 24'h044040, 24'h080101,
                     24'h300a0a, 24'h2c0f00, 24'h3c5a00};
  wide_timer_counter_core #(.FILTER_LEN(4)) u_wide_timer_counter_core (
    .sys_clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_tick_pin_i,
    .capture_trigger_pin_i, .comparator_i, .compare_output_pins_o,
    .irq_ovf_o, .irq_cmpa_o, .irq_cmpb_o, .irq_cap_o);
  cpu_bus_model u_cpu_bus_model (.sys_clk_i, .wb_ack_i(wb_ack_o),
    .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_dat_o(wb_dat_i));
  ////////////////////////////////////////
  // 50 MHz system clock
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_cpu_bus_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_cpu_bus_model.xfer(1'b0, a, 8'h00, q);
  endtask
  // Slow edges so the pin synchroniser sees each level
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk_i);
      ext_tick_pin_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      ext_tick_pin_i <= 1'b0;
    end
    repeat (6) @(posedge sys_clk_i);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(`OFS_POWER);
    chk("power gate", 16'h0001, {8'h00, q});
    wr(`OFS_CTRL_A, 8'h44);
    rd(`OFS_CTRL_A);
    chk("gated write", 16'h0000, {8'h00, q});
    wr(`OFS_POWER, 8'h00);
    $display("reset test done");
    u_cpu_bus_model.gap = 2;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("readback", {8'h00, rows[i].e}, {8'h00, q});
    end
    u_cpu_bus_model.gap = 0;
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_CTRL_C, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h00);
    $display("register table done");
    // Shared latch: CMPB low write reuses the CMPA high byte
    u_cpu_bus_model.wr16(`OFS_CMPA_LO, 16'h1234);
    wr(`OFS_CMPB_LO, 8'h56);
    u_cpu_bus_model.rd16(`OFS_CMPA_LO, v);
    chk("compare a", 16'h1234, v);
    u_cpu_bus_model.rd16(`OFS_CMPB_LO, v);
    chk("compare b", 16'h1256, v);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'h01ff);
    repeat (50) @(posedge sys_clk_i);
    u_cpu_bus_model.rd16(`OFS_CNT_LO, v);
    chk("stopped count", 16'h01ff, v);
    rd(`OFS_CNT_LO);
    rd(`OFS_CAP_LO);
    rd(`OFS_CNT_HI);
    chk("latch shared", 16'h0000, {8'h00, q});
    $display("latch test done");
    // Pin edges as tick, then clear on compare A
    wr(`OFS_CTRL_B, 8'h07);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'h0000);
    ticks(5);
    u_cpu_bus_model.rd16(`OFS_CNT_LO, v);
    chk("pin ticks", 16'h0005, v);
    u_cpu_bus_model.wr16(`OFS_CMPA_LO, 16'h0003);
    wr(`OFS_CTRL_A, 8'h04);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'h0000);
    ticks(6);
    u_cpu_bus_model.rd16(`OFS_CNT_LO, v);
    chk("clear on match", 16'h0002, v);
    $display("tick test done");
    // Overflow interrupt, mask and clear
    wr(`OFS_CTRL_B, 8'h00);
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_IRQ_FLAGS, 8'h0f);
    wr(`OFS_IRQ_MASK, 8'h01);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'hfff0);
    wr(`OFS_CTRL_B, 8'h01);
    for (int i = 0; i < 99 && irq_ovf_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk("overflow irq", 16'h0001, {15'h0, irq_ovf_o});
    wr(`OFS_CTRL_B, 8'h00);
    rd(`OFS_IRQ_FLAGS);
    chk("overflow flag", 16'h0001, {15'h0, q[0]});
    wr(`OFS_IRQ_MASK, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    chk("masked irq", 16'h0000, {15'h0, irq_ovf_o});
    wr(`OFS_IRQ_MASK, 8'h01);
    repeat (3) @(posedge sys_clk_i);
    chk("unmasked irq", 16'h0001, {15'h0, irq_ovf_o});
    wr(`OFS_IRQ_FLAGS, 8'h01);
    repeat (3) @(posedge sys_clk_i);
    chk("cleared irq", 16'h0000, {15'h0, irq_ovf_o});
    $display("overflow test done");
    // Both compare units match on one run; both outputs toggle
    wr(`OFS_IRQ_MASK, 8'h06);
    u_cpu_bus_model.wr16(`OFS_CMPA_LO, 16'h0020);
    u_cpu_bus_model.wr16(`OFS_CMPB_LO, 16'h0040);
    wr(`OFS_CTRL_A, 8'h50);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'h0000);
    wr(`OFS_IRQ_FLAGS, 8'h0f);
    wr(`OFS_CTRL_B, 8'h01);
    for (int i = 0; i < 199 && irq_cmpb_o !== 1'b1; i++) @(posedge sys_clk_i);
    wr(`OFS_CTRL_B, 8'h00);
    chk("match a", 16'h0001, {15'h0, irq_cmpa_o});
    chk("match b", 16'h0001, {15'h0, irq_cmpb_o});
    chk("output a", 16'h0001, {15'h0, compare_output_pins_o[0]});
    chk("output b", 16'h0001, {15'h0, compare_output_pins_o[1]});
    $display("compare test done");
    // Phase correct mode: up to the fixed top, then back down
    wr(`OFS_CTRL_A, 8'h01);
    wr(`OFS_CTRL_B, 8'h07);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'h00fd);
    ticks(4);
    u_cpu_bus_model.rd16(`OFS_CNT_LO, v);
    chk("pwm count", 16'h00fd, v);
    $display("pwm test done");
    // Filtered capture: a short spike is dropped, a steady edge taken
    wr(`OFS_IRQ_MASK, 8'h08);
    u_cpu_bus_model.wr16(`OFS_CNT_LO, 16'h0abc);
    wr(`OFS_CTRL_B, 8'hc0);
    capture_trigger_pin_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    capture_trigger_pin_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    chk("spike", 16'h0000, {15'h0, irq_cap_o});
    capture_trigger_pin_i <= 1'b1;
    for (int i = 0; i < 30 && irq_cap_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk("capture irq", 16'h0001, {15'h0, irq_cap_o});
    u_cpu_bus_model.rd16(`OFS_CAP_LO, v);
    chk("capture value", 16'h0abc, v);
    wr(`OFS_IRQ_FLAGS, 8'h08);
    // Settle the filter low first, or the source switch hides the edge
    capture_trigger_pin_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    wr(`OFS_CTRL_C, 8'h01);
    comparator_i <= 1'b1;
    for (int i = 0; i < 30 && irq_cap_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk("comparator capture", 16'h0001, {15'h0, irq_cap_o});
    $display("capture test done");
    end_sim();
  end
  // Watchdog well beyond the under a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    $display("Error watchdog expected done seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
